//--- rtl/vsse_encoder.sv
// Overview of operation
// - Valve state high when no affecting error.
// - Affecting errors pull valve state low.
// - Codes 16,20,21,22,31 always drop state.
// - Code 19 always drops valve state.
// - Codes 23-26,29 drop on digital, IO-Link.
// - Code 27 digital only; 30 digital/IO-Link.
// - Codes 15,17,18,28,32 never affect state.
// - Feedback mapping same on all variants.
// - De-energised: closed 1, open 0, state 1.
// - Main energised: closed 0, open 1, state 1.
// - Position bit only inside its band.

`timescale 1ns/1ns
`default_nettype none
`include "vsse_regs.svh"

module vsse_encoder
    import vsse_pkg::*;
#(
    parameter logic [31:0] ID_VALUE = 32'h0000_5A5A  // Arbitrary identification value.
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire vsse_avm_req_t avm_req,
    output vsse_avm_rsp_t      avm_rsp,
    input  wire logic [32:0]   error_active,
    input  wire vsse_band_t    band,
    input  wire logic          main_solenoid_drive,
    output logic               valve_state,
    output logic               deenergized_position_feedback,
    output logic               closed_position_input_bit,
    output logic               open_position_input_bit,
    output logic               solenoid_command_output_bit
);

    vsse_state_t s;
    vsse_state_t next_s;

    // ************************************************************
    // Affecting mask selection
    // ************************************************************
    logic [32:0] mask_digital;
    logic [32:0] mask_asi;
    logic [32:0] mask_iolink;
    logic [32:0] mask;
    logic        affected;
    logic        access;

    // ************************************************************
    // Digital variant codes
    // ************************************************************
    always_comb begin
        mask_digital = '0;
        // Codes 0 to 14 are unused and stay clear in every variant.
        // common codes
        mask_digital[`VSSE_CODE_TARGET]    = 1'b1;
        mask_digital[`VSSE_CODE_NOTREACH]  = 1'b1;
        mask_digital[`VSSE_CODE_UNEXPECT]  = 1'b1;
        mask_digital[`VSSE_CODE_SLSMISS]   = 1'b1;
        mask_digital[`VSSE_CODE_SAFESTOP]  = 1'b1;

        mask_digital[`VSSE_CODE_SLSISSUE]  = 1'b1;

        mask_digital[`VSSE_CODE_SV1MISS]   = 1'b1;
        mask_digital[`VSSE_CODE_SV2MISS]   = 1'b1;
        mask_digital[`VSSE_CODE_SV3MISS]   = 1'b1;
        mask_digital[`VSSE_CODE_INTERLOCK] = 1'b1;
        mask_digital[`VSSE_CODE_BUTTON]    = 1'b1;

        // digital codes
        // Code 30 reads as low supply voltage here.
        mask_digital[`VSSE_CODE_SHORT]     = 1'b1;
        mask_digital[`VSSE_CODE_LOWV_COMM] = 1'b1;

        mask_digital[`VSSE_CODE_KEYLOCK]   = 1'b0;
        mask_digital[`VSSE_CODE_PREREQ]    = 1'b0;
        mask_digital[`VSSE_CODE_PNEU]      = 1'b0;
        mask_digital[`VSSE_CODE_ABORT]     = 1'b0;
        mask_digital[`VSSE_CODE_PSHOCK]    = 1'b0;
    end

    // ************************************************************
    // AS-Interface variant codes
    // ************************************************************
    always_comb begin
        mask_asi = '0;
        mask_asi[`VSSE_CODE_TARGET]    = 1'b1;
        mask_asi[`VSSE_CODE_NOTREACH]  = 1'b1;
        mask_asi[`VSSE_CODE_UNEXPECT]  = 1'b1;
        mask_asi[`VSSE_CODE_SLSMISS]   = 1'b1;
        mask_asi[`VSSE_CODE_SAFESTOP]  = 1'b1;

        mask_asi[`VSSE_CODE_SLSISSUE]  = 1'b1;

        mask_asi[`VSSE_CODE_SV1MISS]   = 1'b0;
        mask_asi[`VSSE_CODE_SV2MISS]   = 1'b0;
        mask_asi[`VSSE_CODE_SV3MISS]   = 1'b0;
        mask_asi[`VSSE_CODE_INTERLOCK] = 1'b0;
        mask_asi[`VSSE_CODE_BUTTON]    = 1'b0;

        // not on this variant
        // This variant carries the common codes only.
        mask_asi[`VSSE_CODE_SHORT]     = 1'b0;
        mask_asi[`VSSE_CODE_LOWV_COMM] = 1'b0;

        mask_asi[`VSSE_CODE_KEYLOCK]   = 1'b0;
        mask_asi[`VSSE_CODE_PREREQ]    = 1'b0;
        mask_asi[`VSSE_CODE_PNEU]      = 1'b0;
        mask_asi[`VSSE_CODE_ABORT]     = 1'b0;
        mask_asi[`VSSE_CODE_PSHOCK]    = 1'b0;
    end

    // ************************************************************
    // IO-Link variant codes
    // ************************************************************
    always_comb begin
        mask_iolink = '0;
        mask_iolink[`VSSE_CODE_TARGET]    = 1'b1;
        mask_iolink[`VSSE_CODE_NOTREACH]  = 1'b1;
        mask_iolink[`VSSE_CODE_UNEXPECT]  = 1'b1;
        mask_iolink[`VSSE_CODE_SLSMISS]   = 1'b1;
        mask_iolink[`VSSE_CODE_SAFESTOP]  = 1'b1;

        mask_iolink[`VSSE_CODE_SLSISSUE]  = 1'b1;

        mask_iolink[`VSSE_CODE_SV1MISS]   = 1'b1;
        mask_iolink[`VSSE_CODE_SV2MISS]   = 1'b1;
        mask_iolink[`VSSE_CODE_SV3MISS]   = 1'b1;
        mask_iolink[`VSSE_CODE_INTERLOCK] = 1'b1;
        mask_iolink[`VSSE_CODE_BUTTON]    = 1'b1;

        // comm failure
        // Code 30 reads as communication failure here.
        mask_iolink[`VSSE_CODE_SHORT]     = 1'b0;
        mask_iolink[`VSSE_CODE_LOWV_COMM] = 1'b1;

        mask_iolink[`VSSE_CODE_KEYLOCK]   = 1'b0;
        mask_iolink[`VSSE_CODE_PREREQ]    = 1'b0;
        mask_iolink[`VSSE_CODE_PNEU]      = 1'b0;
        mask_iolink[`VSSE_CODE_ABORT]     = 1'b0;
        mask_iolink[`VSSE_CODE_PSHOCK]    = 1'b0;
    end

    // ************************************************************
    // Variant selection
    // ************************************************************
    // The selected mask follows the variant register at once, so a
    // variant write changes the valve state on the next edge.
    always_comb begin
        unique case (s.variant)
            VSSE_VAR_DIGITAL: mask = mask_digital;
            VSSE_VAR_IOLINK:  mask = mask_iolink;
            // The spare code behaves as the AS-Interface variant.
            VSSE_VAR_ASI,
            VSSE_VAR_SPARE:   mask = mask_asi;
        endcase
    end

    assign affected = |(s.errors_sync2 & mask);

    // Waitrequest is combinational so that the master sees it in the
    // cycle of its request; rsp_done marks the answering cycle.
    assign access = (avm_req.read | avm_req.write) & ~s.rsp_done;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_s = s;

        // Every pin input passes two flops before any logic reads it, so
        // three edges pass from a pin change to the feedback outputs.
        next_s.errors_sync1 = error_active;
        next_s.errors_sync2 = s.errors_sync1;
        next_s.band_sync1   = band;
        next_s.band_sync2   = s.band_sync1;
        next_s.sv_sync1     = main_solenoid_drive;
        next_s.sv_sync2     = s.sv_sync1;

        // ********************************************************
        // Valve state and feedback
        // ********************************************************
        // The closed bit, and with it the de-energised pin, carries the de-energised band; the open bit the open band.
        // high when clear
        next_s.fb.valve_state = ~affected;
        next_s.fb.closed_position_input_bit = s.band_sync2[1];
        next_s.fb.open_position_input_bit = s.band_sync2[0];

        // ********************************************************
        // Bus handshake and control write
        // ********************************************************
        // One wait state per access, then done for one cycle.
        next_s.rsp_done = access;

        // The write lands on the edge at which waitrequest is low, the
        // same edge at which the master completes the transfer.
        if (s.rsp_done && avm_req.write && avm_req.address == `VSSE_OFF_CTRL) begin
            // Only byte lane 0 carries control fields.
            if (avm_req.byteenable[0]) begin
                next_s.variant = vsse_variant_t'(
                    avm_req.writedata[`VSSE_CTRL_VAR_MSB:`VSSE_CTRL_VAR_LSB]);
                next_s.cmd_sw = avm_req.writedata[`VSSE_CTRL_CMD_BIT];
            end
        end

        // ********************************************************
        // Read data
        // ********************************************************
        // Read data stand only in the answering cycle and are zero otherwise.
        next_s.rdata = 32'h0000_0000;
        if (access && avm_req.read) begin
            // Unmapped addresses read as zero.
            unique case (avm_req.address)
                `VSSE_OFF_CTRL: begin
                    next_s.rdata[`VSSE_CTRL_VAR_MSB:`VSSE_CTRL_VAR_LSB] = s.variant;
                    next_s.rdata[`VSSE_CTRL_CMD_BIT] = s.cmd_sw;
                end
                `VSSE_OFF_ERRORS: begin
                    next_s.rdata = s.errors_sync2[31:0] & mask[31:0];
                end
                `VSSE_OFF_STATUS: begin
                    next_s.rdata[`VSSE_ST_VSTATE_BIT] = s.fb.valve_state;
                    next_s.rdata[`VSSE_ST_DEEN_BIT]   = s.fb.closed_position_input_bit;
                    next_s.rdata[`VSSE_ST_OPEN_BIT]   = s.fb.open_position_input_bit;
                    // Bit 3 shows the synchronised solenoid input, not the command.
                    next_s.rdata[`VSSE_ST_CMD_BIT]    = s.sv_sync2;
                end
                `VSSE_OFF_ID: begin
                    next_s.rdata = ID_VALUE;
                end
                default: begin
                    next_s.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Reset clears the feedback, so the valve state reads low until
    // the first edge after release.
    always_ff @(posedge clk) begin
        if (rst) begin
            s.variant      <= VSSE_VAR_DIGITAL;
            s.cmd_sw       <= 1'b0;
            s.errors_sync1 <= '0;
            s.errors_sync2 <= '0;
            s.band_sync1   <= '0;
            s.band_sync2   <= '0;
            s.sv_sync1     <= 1'b0;
            s.sv_sync2     <= 1'b0;
            s.fb           <= '0;
            s.rsp_done     <= 1'b0;
            s.rdata        <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign avm_rsp.readdata    = s.rdata;
    assign avm_rsp.waitrequest = (avm_req.read | avm_req.write) & ~s.rsp_done;

    assign valve_state                   = s.fb.valve_state;
    assign closed_position_input_bit     = s.fb.closed_position_input_bit;
    assign deenergized_position_feedback = s.fb.closed_position_input_bit;
    assign open_position_input_bit       = s.fb.open_position_input_bit;
    // The plant sees the synchronised input or the software command.
    assign solenoid_command_output_bit   = s.sv_sync2 | s.cmd_sw;

endmodule

`default_nettype wire

//--- rtl/vsse_pkg.sv
package vsse_pkg;

    // Interface variant of the control head.
    typedef enum logic [1:0] {
        VSSE_VAR_DIGITAL = 2'h0,
        VSSE_VAR_ASI     = 2'h1,
        VSSE_VAR_IOLINK  = 2'h2,
        VSSE_VAR_SPARE   = 2'h3
    } vsse_variant_t;

    // Position sensor band indications.
    typedef struct packed {
        logic in_deen_band;
        logic in_open_band;
    } vsse_band_t;

    // Feedback bits toward the plant controller.
    typedef struct packed {
        logic valve_state;
        logic closed_position_input_bit;
        logic open_position_input_bit;
    } vsse_feedback_t;

    // Avalon-MM slave request.
    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } vsse_avm_req_t;

    // Avalon-MM slave answer.
    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } vsse_avm_rsp_t;

    // All state of the encoder.
    typedef struct packed {
        vsse_variant_t  variant;
        logic           cmd_sw;
        logic [32:0]    errors_sync1;
        logic [32:0]    errors_sync2;
        logic [1:0]     band_sync1;
        logic [1:0]     band_sync2;
        logic           sv_sync1;
        logic           sv_sync2;
        vsse_feedback_t fb;
        logic           rsp_done;
        logic [31:0]    rdata;
    } vsse_state_t;

endpackage

//--- rtl/vsse_regs.svh
`ifndef VSSE_REGS_SVH
`define VSSE_REGS_SVH

// Register offsets (byte addresses, one aligned word each).
`define VSSE_OFF_CTRL    4'h0
`define VSSE_OFF_ERRORS  4'h4
`define VSSE_OFF_STATUS  4'h8
`define VSSE_OFF_ID      4'hC

// Control register fields.
`define VSSE_CTRL_VAR_LSB   0
`define VSSE_CTRL_VAR_MSB   1
`define VSSE_CTRL_CMD_BIT   2

// Status register fields.
`define VSSE_ST_VSTATE_BIT  0
`define VSSE_ST_DEEN_BIT    1
`define VSSE_ST_OPEN_BIT    2
`define VSSE_ST_CMD_BIT     3

// Reset values.
`define VSSE_CTRL_RESET     32'h0000_0000

// Error code numbering: the condition vector bit n stands for code n.
`define VSSE_CODE_KEYLOCK   15
`define VSSE_CODE_TARGET    16
`define VSSE_CODE_PREREQ    17
`define VSSE_CODE_PNEU      18
`define VSSE_CODE_SLSISSUE  19
`define VSSE_CODE_NOTREACH  20
`define VSSE_CODE_UNEXPECT  21
`define VSSE_CODE_SLSMISS   22
`define VSSE_CODE_SV1MISS   23
`define VSSE_CODE_SV2MISS   24
`define VSSE_CODE_SV3MISS   25
`define VSSE_CODE_INTERLOCK 26
`define VSSE_CODE_SHORT     27
`define VSSE_CODE_ABORT     28
`define VSSE_CODE_BUTTON    29
`define VSSE_CODE_LOWV_COMM 30
`define VSSE_CODE_SAFESTOP  31
`define VSSE_CODE_PSHOCK    32

// Affecting-condition masks per variant, bit n = code n.
`define VSSE_MASK_COMMON    33'h0_807F_0000
`define VSSE_MASK_COMMON2   33'h0_0000_0000
`define VSSE_MASK_DIGITAL   33'h0_EFF9_0000
`define VSSE_MASK_ASI       33'h0_8079_0000
`define VSSE_MASK_IOLINK    33'h0_E7F9_0000

`endif

//--- tb/vsse_encoder_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Encoder port checks.
// ****
module vsse_chk
    import vsse_pkg::*;
#(
    parameter logic [31:0] ID_VALUE = 32'h0000_5A5A
) (
    input wire logic          clk,
    input wire logic          rst,
    input wire vsse_avm_req_t avm_req,
    input wire vsse_avm_rsp_t avm_rsp,
    input wire logic [32:0]   error_active,
    input wire vsse_band_t    band,
    input wire logic          main_solenoid_drive,
    input wire logic          valve_state,
    input wire logic          deenergized_position_feedback,
    input wire logic          closed_position_input_bit,
    input wire logic          open_position_input_bit,
    input wire logic          solenoid_command_output_bit
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic req = avm_req.read | avm_req.write;
    wire logic dn = band.in_deen_band;
    wire logic op = band.in_open_band;
    common_drop_a: assert property ((|(error_active & 33'h0_8079_0000))[*3] |=> !valve_state)
        else $error("state high on error");
    no_error_a: assert property (((error_active[31:16] & 16'hEFF9) == 16'h0)[*3] |=> valve_state)
        else $error("state low with no error");
    fb_same_a: assert property (deenergized_position_feedback == closed_position_input_bit)
        else $error("feedback copies differ");
    closed_band_a: assert property (dn[*3] |=> closed_position_input_bit)
        else $error("closed bit missing");
    open_band_a: assert property (op[*3] |=> open_position_input_bit)
        else $error("open bit missing");
    between_a: assert property ((!dn && !op)[*3] |=> !closed_position_input_bit && !open_position_input_bit)
        else $error("position lit between bands");
    sol_cmd_a: assert property (main_solenoid_drive[*3] |=> solenoid_command_output_bit)
        else $error("solenoid command lost");
    one_wait_a: assert property (req && avm_rsp.waitrequest |=> !avm_rsp.waitrequest)
        else $error("wait state too long");
    idle_wait_a: assert property (!req |-> !avm_rsp.waitrequest)
        else $error("wait without request");
    id_read_a: assert property (avm_req.read && avm_req.address == 4'hC && !avm_rsp.waitrequest
        |-> avm_rsp.readdata == ID_VALUE) else $error("bad id word");
    cover property ($fell(valve_state));
    cover property ((!dn && !op)[*3]);
    cover property ($rose(open_position_input_bit));
endmodule
bind vsse_encoder vsse_chk #(.ID_VALUE(ID_VALUE)) vsse_chk_inst (.*);
`default_nettype wire

//--- tb/vsse_encoder_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Encoder bench.
// ****
module vsse_encoder_tb
    import vsse_pkg::*;
;
    logic          clk = 0, rst = 1, drv = 0, vs, dn, cl, op, cmd;
    vsse_avm_req_t req = '0;
    vsse_avm_rsp_t rsp;
    vsse_band_t    band;
    logic [32:0]   err = '0;
    logic [31:0]   q;
    int            error_cnt = 0, n_checks = 0, cyc = 0;
    vsse_encoder vsse_encoder_inst (.clk(clk), .rst(rst), .avm_req(req), .avm_rsp(rsp), .error_active(err),
        .band(band), .main_solenoid_drive(drv), .valve_state(vs), .deenergized_position_feedback(dn),
        .closed_position_input_bit(cl), .open_position_input_bit(op), .solenoid_command_output_bit(cmd));
    vsse_plant vsse_plant_inst (.clk(clk), .cmd(cmd), .band(band));
    initial forever #50 clk = ~clk;
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %0t %h %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: 4'hF};
        do @(posedge clk); while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata;
        req <= '0;
    endtask
    task automatic put(input logic [32:0] e, input int n);
        @(posedge clk);
        err <= e;
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    function automatic logic drops(int v, int c);
        if (c inside {16, [19:22], 31}) return 1;
        if (c inside {[23:26], 29, 30}) return v != 1;
        return c == 27 && v == 0;
    endfunction
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        bus(0, 4'hC, 0);
        chk(q, 32'h0000_5A5A);
        bus(0, 4'h1, 0);
        chk(q, 32'h0);
        bus(0, 4'h0, 0);
        chk(q, 32'h0);
        for (int v = 0; v < 3; v++) begin
            bus(1, 4'h0, v);
            for (int c = 15; c < 33; c++) begin
                put(33'h1 << c, 5);
                chk(vs, !drops(v, c));
                put(33'h0, 5);
                chk(vs, 1);
            end
        end
        put(33'h0_4001_0000, 5);
        chk(vs, 0);
        put(33'h0_4000_0000, 5);
        chk(vs, 0);
        put(33'h0, 5);
        chk({cl, dn, op, vs}, 4'hD);
        @(posedge clk);
        drv <= 1;
        put(33'h0, 20);
        chk({cl, dn, op, vs}, 4'h3);
        @(posedge clk);
        drv <= 0;
        bus(1, 4'h1, 4);
        bus(1, 4'h1, 4);
        put(33'h0, 20);
        chk({cl, dn, op, vs}, 4'hD);
        bus(1, 4'h0, 4);
        put(33'h0, 20);
        chk(op, 1);
        chk(cmd, 1);
        bus(0, 4'h8, 0);
        chk(q, 32'h5);
        bus(0, 4'h0, 0);
        chk(q, 32'h4);
        stop_test();
    end
endmodule
`default_nettype wire

//--- tb/vsse_plant.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Valve stem and position sensor.
// ****
module vsse_plant
    import vsse_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      cmd,
    output var vsse_band_t band
);
    int pos = 0;
    always @(posedge clk) pos <= cmd ? (pos < 6 ? pos + 1 : 6) : (pos > 0 ? pos - 1 : 0);
    assign band = {pos == 0, pos == 6};
endmodule
`default_nettype wire
